// *** rtl/ppgt_ctrl.sv ***
/*
  start, stop and capture control of a 10-bit up-counting pulse timer,
  with an apb register slave. holds the counter, the start phase, the
  capture buffers and the read-protected capture registers.
  assumes synchronous apb inputs, one clock, and software that reads the
  capture bytes in the order low a, high a, low b, high b.
*/
// Operation
// (R01) source 00 command with capture, 01 command plus trigger, 10 trigger
// (R02) command modes: writing run 1 clears count and counts from zero
// (R03) at period end counter clears, then repeats or halts per stop mode
// (R04) rewriting run 1 before period end clears counter and continues
// (R05) command plus trigger: start edge starts, clear level holds cleared
// (R06) command during clear level waits for start edge, then trigger irq
// (R07) trigger-only mode: run write neither starts count nor inits outputs
// (R08) trigger-only mode: run 1 arms the timer to wait for start edge
// (R09) capture mode records count at rising edge to a, falling to b
// (R10) captures pass through buffer, moved at period end, kept if no edge
// (R11) several edges in one period: the last captured value wins
// (R12) software reads low a, high a, low b, high b in that order
// (R13) reading any capture byte but fall high protects; fall high unprotects
// (R14) software dummy-reads captures in the first period to unprotect
// (R15) captures update only while run is 1; none after one-time stop
// (R16) polarity 0: falling edge starts, high level clears and stops
// (R17) polarity 1: rising edge starts, low level clears and stops
// (R18) one-time stop pending: stop trigger accepted, start trigger ignored
// (R19) with run at 0 every pin trigger is ignored; code still takes the stop trigger while a one-time stop drains
// (R20) stop mode 10 is one-time: counter halts at period end
// (R21) stop mode 00 or 01 is continuous: periods repeat
// (R22) period interrupt fires when count matches period data; code matches count against period data minus one
// (R23) trigger pin synchronised, edges from successive synchronised samples
`timescale 1ns/1ns
module ppgt_ctrl
#(
  parameter int CNT_W = ppgt_pkg::CNT_W
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic trigger_input_pin_i,
  output logic period_match_interrupt_o,
  output logic trigger_start_interrupt_o,
  output logic pulse_init_o,
  output logic counting_o,
  output logic [CNT_W-1:0] count_o
);

  if (CNT_W != ppgt_pkg::CNT_W)
  begin : g_bad_width
    $error("counter width must match the register layout");
  end

  typedef struct packed {
    logic run;
    logic [1:0] stop_mode_field;
    logic [1:0] start_source_select;
    logic trigger_edge_polarity;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] cnt;
    ppgt_pkg::ppgt_phase_t phase;
    logic [CNT_W-1:0] buf_rise;
    logic [CNT_W-1:0] buf_fall;
    logic [CNT_W-1:0] rise_capture_reg;
    logic [CNT_W-1:0] fall_capture_reg;
    logic protect;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq_period;
    logic irq_trig;
    logic init;
    logic counting;
  } ppgt_state_t;

  ppgt_state_t s_q;
  ppgt_state_t s_d;

  ppgt_trig_if trig ();

  ppgt_trig_sync u_sync
  (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .trigger_input_pin_i(trigger_input_pin_i),
    .trig(trig)
  );

  ////////////////////////////////////////////////////////////////////////

  logic cmd_en;
  logic trg_en;
  logic cap_en;
  logic one_time;
  logic start_edge;
  logic stop_level;
  logic period_end;
  logic active;
  logic setup;
  logic acc_wr;
  logic acc_rd;
  logic new_run;
  logic [1:0] new_stm;
  logic [1:0] new_src;
  logic new_pol;
  logic new_stop_level;

  always_comb
  begin
    cmd_en = (s_q.start_source_select == ppgt_pkg::SRC_CMD_CAP)
      || (s_q.start_source_select == ppgt_pkg::SRC_CMD_TRG); // R01
    trg_en = (s_q.start_source_select == ppgt_pkg::SRC_CMD_TRG)
      || (s_q.start_source_select == ppgt_pkg::SRC_TRG_ONLY); // R01
    cap_en = s_q.start_source_select == ppgt_pkg::SRC_CMD_CAP; // R01
    one_time = s_q.stop_mode_field == ppgt_pkg::STOP_ONE_TIME; // R20 R21
    // R16 R17
    start_edge = s_q.trigger_edge_polarity ? trig.rise : trig.fall;
    stop_level = s_q.trigger_edge_polarity ? ~trig.level : trig.level;
    active = (s_q.phase == ppgt_pkg::PH_COUNT)
      || (s_q.phase == ppgt_pkg::PH_DRAIN);
    // a 10-bit wrap makes period 0 mean 400h counts
    period_end = active && (s_q.cnt == s_q.period - 1'b1); // R22
    setup = psel_i && !penable_i;
    acc_wr = psel_i && penable_i && s_q.pready && pwrite_i;
    acc_rd = psel_i && penable_i && s_q.pready && !pwrite_i;
    new_run = pwdata_i[ppgt_pkg::CTRL_RUN_BIT];
    new_stm = pwdata_i[ppgt_pkg::CTRL_STOP_LSB +: 2];
    new_src = pwdata_i[ppgt_pkg::CTRL_SRC_LSB +: 2];
    new_pol = pwdata_i[ppgt_pkg::CTRL_POL_BIT];
    new_stop_level = new_pol ? ~trig.level : trig.level;
  end

  ////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    s_d = s_q;
    s_d.irq_period = 1'b0;
    s_d.irq_trig = 1'b0;
    s_d.init = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;

    // counting and period end
    if (active)
    begin
      if (period_end)
      begin
        s_d.cnt = '0; // R03
        s_d.irq_period = 1'b1; // R22
        if (!s_q.protect)
        begin
          // buffers keep old values when no edge came in the period
          s_d.rise_capture_reg = s_q.buf_rise; // R10
          s_d.fall_capture_reg = s_q.buf_fall; // R10
        end
        if (s_q.phase == ppgt_pkg::PH_DRAIN)
          s_d.phase = ppgt_pkg::PH_STOP; // R20
        else if (one_time)
          s_d.phase = trg_en ? ppgt_pkg::PH_WAIT : ppgt_pkg::PH_STOP; // R20
      end
      else
        s_d.cnt = s_q.cnt + 1'b1;
    end

    // capture while running; later edges overwrite earlier ones
    if (cap_en && s_q.run && s_q.phase == ppgt_pkg::PH_COUNT) // R15
    begin
      if (trig.rise)
        s_d.buf_rise = s_q.cnt; // R09 R11
      if (trig.fall)
        s_d.buf_fall = s_q.cnt; // R09 R11
    end

    // pin triggers, only while run is set or a one-time stop drains
    if (trg_en && (s_q.run || s_q.phase == ppgt_pkg::PH_DRAIN)) // R19
    begin
      if (stop_level)
      begin
        s_d.cnt = '0; // R05 R16 R17
        if (s_q.phase == ppgt_pkg::PH_DRAIN)
        begin
          s_d.phase = ppgt_pkg::PH_STOP; // R18
          s_d.init = 1'b1;
        end
        else if (s_q.phase == ppgt_pkg::PH_COUNT)
        begin
          s_d.phase = ppgt_pkg::PH_WAIT; // R05
          s_d.init = 1'b1; // R16 R17
        end
      end
      else if (start_edge && s_q.phase == ppgt_pkg::PH_WAIT)
      begin
        s_d.phase = ppgt_pkg::PH_COUNT; // R05 R06 R08
        s_d.cnt = '0;
        s_d.irq_trig = 1'b1; // R06
      end
    end

    ////////////////////////////////////////////////////////////////////
    // register writes, taken at the access edge

    if (acc_wr && paddr_i == ppgt_pkg::OFS_CTRL)
    begin
      s_d.run = new_run;
      s_d.stop_mode_field = new_stm;
      s_d.start_source_select = new_src;
      s_d.trigger_edge_polarity = new_pol;
      if (new_run)
      begin
        if (new_src == ppgt_pkg::SRC_CMD_CAP
          || new_src == ppgt_pkg::SRC_CMD_TRG)
        begin
          s_d.cnt = '0; // R02 R04
          s_d.init = 1'b1;
          // a clear level at the pin outranks the command
          if (new_src == ppgt_pkg::SRC_CMD_TRG && new_stop_level)
            s_d.phase = ppgt_pkg::PH_WAIT; // R06
          else
            s_d.phase = ppgt_pkg::PH_COUNT; // R02 R04
        end
        else if (s_q.phase == ppgt_pkg::PH_STOP)
          s_d.phase = ppgt_pkg::PH_WAIT; // R07 R08
      end
      else if (s_q.run && s_q.phase == ppgt_pkg::PH_COUNT
        && new_stm == ppgt_pkg::STOP_ONE_TIME)
        s_d.phase = ppgt_pkg::PH_DRAIN; // R18 R20
      else if (s_q.phase != ppgt_pkg::PH_DRAIN)
      begin
        s_d.phase = ppgt_pkg::PH_STOP;
        s_d.cnt = '0;
        // hold mode keeps the pulse outputs where they stand
        s_d.init = new_stm != ppgt_pkg::STOP_HOLD;
      end
    end

    if (acc_wr && paddr_i == ppgt_pkg::OFS_PERIOD)
      s_d.period = pwdata_i[CNT_W-1:0];

    // capture reads: protection clears only on the last byte
    if (acc_rd)
    begin
      if (paddr_i == ppgt_pkg::OFS_RISE_LOW
        || paddr_i == ppgt_pkg::OFS_RISE_HIGH
        || paddr_i == ppgt_pkg::OFS_FALL_LOW)
        s_d.protect = 1'b1; // R13 R14
      else if (paddr_i == ppgt_pkg::OFS_FALL_HIGH)
        s_d.protect = 1'b0; // R13 R14
    end

    ////////////////////////////////////////////////////////////////////
    // read data prepared in the setup cycle; pready rises in the first access cycle, no wait state

    if (setup)
    begin
      s_d.pready = 1'b1;
      s_d.prdata = '0;
      case (paddr_i)
        ppgt_pkg::OFS_CTRL:
        begin
          s_d.prdata[ppgt_pkg::CTRL_RUN_BIT] = s_q.run;
          s_d.prdata[ppgt_pkg::CTRL_STOP_LSB +: 2] = s_q.stop_mode_field;
          s_d.prdata[ppgt_pkg::CTRL_SRC_LSB +: 2] = s_q.start_source_select;
          s_d.prdata[ppgt_pkg::CTRL_POL_BIT] = s_q.trigger_edge_polarity;
        end
        ppgt_pkg::OFS_PERIOD:
          s_d.prdata[CNT_W-1:0] = s_q.period;
        ppgt_pkg::OFS_STATUS:
        begin
          s_d.prdata[ppgt_pkg::STAT_CNT_LSB +: CNT_W] = s_q.cnt;
          s_d.prdata[ppgt_pkg::STAT_PHASE_LSB +: 2] = s_q.phase;
          s_d.prdata[ppgt_pkg::STAT_PROT_BIT] = s_q.protect;
        end
        ppgt_pkg::OFS_RISE_LOW:
          s_d.prdata[7:0] = s_q.rise_capture_reg[7:0];
        ppgt_pkg::OFS_RISE_HIGH:
          s_d.prdata[CNT_W-9:0] = s_q.rise_capture_reg[CNT_W-1:8];
        ppgt_pkg::OFS_FALL_LOW:
          s_d.prdata[7:0] = s_q.fall_capture_reg[7:0];
        ppgt_pkg::OFS_FALL_HIGH:
          s_d.prdata[CNT_W-9:0] = s_q.fall_capture_reg[CNT_W-1:8];
        default:
          s_d.pslverr = 1'b1;
      endcase
    end

    // kept as a flop so the output needs no decode after the register
    s_d.counting = s_d.phase == ppgt_pkg::PH_COUNT
      || s_d.phase == ppgt_pkg::PH_DRAIN;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      s_q <= '0;
      s_q.stop_mode_field <= ppgt_pkg::STOP_RST;
      s_q.start_source_select <= ppgt_pkg::SRC_RST;
      s_q.trigger_edge_polarity <= ppgt_pkg::POL_RST;
      s_q.period <= ppgt_pkg::PERIOD_RST;
      s_q.phase <= ppgt_pkg::PH_STOP;
    end
    else
      s_q <= s_d;
  end

  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign period_match_interrupt_o = s_q.irq_period;
  assign trigger_start_interrupt_o = s_q.irq_trig;
  assign pulse_init_o = s_q.init;
  assign counting_o = s_q.counting;
  assign count_o = s_q.cnt;

endmodule

// *** rtl/ppgt_pkg.sv ***
/*
  constants and shared types of the pulse timer start, stop and capture
  control: register offsets, field positions, reset values, encodings.
  assumes a 32-bit apb slave with one register per aligned word.
*/
package ppgt_pkg;

  localparam int CNT_W = 10;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RISE_LOW = 8'h0c;
  localparam logic [7:0] OFS_RISE_HIGH = 8'h10;
  localparam logic [7:0] OFS_FALL_LOW = 8'h14;
  localparam logic [7:0] OFS_FALL_HIGH = 8'h18;

  // control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_STOP_LSB = 1;
  localparam int CTRL_SRC_LSB = 3;
  localparam int CTRL_POL_BIT = 5;

  // status register fields
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_PHASE_LSB = 16;
  localparam int STAT_PROT_BIT = 18;

  // reset values
  localparam logic [1:0] STOP_RST = 2'h0;
  localparam logic [1:0] SRC_RST = 2'h0;
  localparam logic POL_RST = 1'b0;
  localparam logic [9:0] PERIOD_RST = 10'h000;

  // start source encodings
  localparam logic [1:0] SRC_CMD_CAP = 2'h0;
  localparam logic [1:0] SRC_CMD_TRG = 2'h1;
  localparam logic [1:0] SRC_TRG_ONLY = 2'h2;

  // stop mode encodings
  localparam logic [1:0] STOP_INIT = 2'h0;
  localparam logic [1:0] STOP_HOLD = 2'h1;
  localparam logic [1:0] STOP_ONE_TIME = 2'h2;

  typedef enum logic [1:0] {
    PH_STOP,
    PH_COUNT,
    PH_WAIT,
    PH_DRAIN
  } ppgt_phase_t;

endpackage

// *** rtl/ppgt_trig_if.sv ***
/*
  synchronised trigger level and its edge pulses, passed from the
  trigger input stage to the timer control.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface ppgt_trig_if;
  logic level;
  logic rise;
  logic fall;

  modport src
  (
    output level,
    output rise,
    output fall
  );

  modport dst
  (
    input level,
    input rise,
    input fall
  );
endinterface

// *** rtl/ppgt_trig_sync.sv ***
/*
  trigger pin input stage: two-flop synchroniser, then edge detection
  from successive synchronised samples.
  assumes the pin may change at any time relative to clk_i.
*/
`timescale 1ns/1ns
module ppgt_trig_sync
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic trigger_input_pin_i,
  ppgt_trig_if.src trig
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic rise;
    logic fall;
  } ppgt_sync_t;

  ppgt_sync_t s_q;
  ppgt_sync_t s_d;

  // meta feeds only the sync flop; edges come from sync and prev
  always_comb
  begin
    s_d = s_q;
    s_d.meta = trigger_input_pin_i; // R23
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    s_d.rise = s_q.sync & ~s_q.prev; // R23
    s_d.fall = ~s_q.sync & s_q.prev;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign trig.level = s_q.prev;
  assign trig.rise = s_q.rise;
  assign trig.fall = s_q.fall;

endmodule

// *** test/ppgt_ctrl_props.sv ***
/*
  concurrent checks on the timer control ports.
  assumes it is bound to ppgt_ctrl and sees one clock.
*/
`timescale 1ns/1ns
module ppgt_ctrl_props
#(
  parameter int CNT_W = 10
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic trigger_input_pin_i,
  input wire logic period_match_interrupt_o,
  input wire logic trigger_start_interrupt_o,
  input wire logic pulse_init_o,
  input wire logic counting_o,
  input wire logic [CNT_W-1:0] count_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////
  sequence s_run_wr;
    psel_i && penable_i && pready_o && pwrite_i &&
      paddr_i == ppgt_pkg::OFS_CTRL && pwdata_i[0];
  endsequence
  sequence s_cmd_wr;
    s_run_wr ##0 pwdata_i[4:3] == ppgt_pkg::SRC_CMD_CAP;
  endsequence
  sequence s_trg_wr;
    s_run_wr ##0 pwdata_i[4:3] == ppgt_pkg::SRC_TRG_ONLY;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  AST_ONE_WAIT: assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready not one cycle after setup");
  AST_ERR_MAP: assert property (pslverr_o |-> pready_o &&
    (paddr_i > ppgt_pkg::OFS_FALL_HIGH || paddr_i[1:0] != 2'h0))
    else $error("slave error on a mapped address");
  AST_CMD_START: assert property (
    s_cmd_wr |=> count_o == '0 && pulse_init_o && counting_o)
    else $error("command start did not clear and run");
  AST_TRG_NO_INIT: assert property (s_trg_wr |=> !pulse_init_o)
    else $error("run write in trigger mode reinitialised outputs");
  AST_WRAP: assert property (
    period_match_interrupt_o |-> count_o == '0 && $past(counting_o))
    else $error("period pulse without counter clear");
  AST_STEP: assert property (
    count_o != '0 |-> count_o - 1'b1 == $past(count_o) && counting_o)
    else $error("counter did not step by one");
  AST_IDLE_ZERO: assert property (!counting_o |-> count_o == '0)
    else $error("stopped counter not cleared");
  AST_TRG_START: assert property (
    trigger_start_interrupt_o |-> counting_o && count_o == '0 &&
      !$past(counting_o))
    else $error("trigger start not from a waiting counter");
  AST_TRG_ONCE: assert property (
    trigger_start_interrupt_o |=> !trigger_start_interrupt_o [*2])
    else $error("trigger start pulse repeated");
endmodule

bind ppgt_ctrl ppgt_ctrl_props #(.CNT_W(CNT_W)) ppgt_ctrl_props_inst
(
  .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .trigger_input_pin_i(trigger_input_pin_i),
  .period_match_interrupt_o(period_match_interrupt_o),
  .trigger_start_interrupt_o(trigger_start_interrupt_o),
  .pulse_init_o(pulse_init_o), .counting_o(counting_o),
  .count_o(count_o)
);

// *** test/ppgt_trig_src.sv ***
/*
  stand-in for the signal source on the trigger pin.
  assumes the bench asks for a level; the pin follows at the next edge.
*/
`timescale 1ns/1ns
module ppgt_trig_src
(
  input wire logic clk_i,
  input wire logic lvl_i,
  output logic pin_o
);
  // driven from a flop so the pin never moves in the sampling step
  initial pin_o = 1'b0;
  always @(posedge clk_i)
  begin
    pin_o <= lvl_i;
  end
endmodule

// *** test/tb.sv ***
/*
  self-checking bench: apb register accesses and trigger pin stimulus.
  assumes an apb slave that raises pready on its own, and a 10-bit counter.
*/
`timescale 1ns/1ns
module tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, pin, err, pm_irq, ts_irq, init_p, cnting;
  logic lvl = 1'b0;
  logic [9:0] cnt, ra, fa, a, b;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int wn;
  ppgt_ctrl ppgt_ctrl_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .trigger_input_pin_i(pin), .period_match_interrupt_o(pm_irq),
    .trigger_start_interrupt_o(ts_irq), .pulse_init_o(init_p),
    .counting_o(cnting), .count_o(cnt));
  ppgt_trig_src ppgt_trig_src_inst (.clk_i(clk_i), .lvl_i(lvl),
    .pin_o(pin));
  initial forever #2 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (error_cnt == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      end_of_test;
    end
  end
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // no wait limit here: the cycle ceiling ends a hung transfer
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // s 0: period pulse, 1: trigger start pulse; wn counts the edges
  task automatic wait_for(input logic s, input int lim);
    wn = 0;
    do
    begin
      @(posedge clk_i);
      wn++;
    end
    while ((s ? ts_irq : pm_irq) !== 1'b1 && wn < lim);
    chk("event", 32'(wn < lim), 1);
  endtask
  task automatic pulse(input int r, input int f);
    repeat (r) @(posedge clk_i);
    lvl <= 1'b1;
    repeat (f - r) @(posedge clk_i);
    lvl <= 1'b0;
  endtask
  task automatic rd_cap(output logic [9:0] x, output logic [9:0] y);
    apb(0, ppgt_pkg::OFS_RISE_LOW, 0);
    x[7:0] = rd[7:0];
    apb(0, ppgt_pkg::OFS_RISE_HIGH, 0);
    x[9:8] = rd[1:0];
    apb(0, ppgt_pkg::OFS_FALL_LOW, 0);
    y[7:0] = rd[7:0];
    apb(0, ppgt_pkg::OFS_FALL_HIGH, 0);
    y[9:8] = rd[1:0];
  endtask
  task automatic wr_ctl(input logic r, input logic [1:0] sm,
    input logic [1:0] sc, input logic p);
    apb(1, ppgt_pkg::OFS_CTRL, {26'h0, p, sc, sm, r});
  endtask
  task automatic run_chk(input logic e, input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
    chk("counting", cnting, e);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    apb(0, ppgt_pkg::OFS_CTRL, 0);
    chk("ctrl reset", rd, 0);
    chk("no slverr", err, 0);
    apb(0, ppgt_pkg::OFS_STATUS, 0);
    chk("status reset", rd, 0);
    apb(0, 8'h1c, 0);
    chk("unmapped", err, 1);
    apb(1, ppgt_pkg::OFS_PERIOD, 32'h20);
    wr_ctl(1, ppgt_pkg::STOP_INIT, ppgt_pkg::SRC_CMD_CAP, 0);
    wait_for(0, 100);
    wait_for(0, 100);
    chk("period", wn, 32);
    wr_ctl(1, ppgt_pkg::STOP_INIT, ppgt_pkg::SRC_CMD_CAP, 0);
    wait_for(0, 100);
    chk("restart", wn, 33);
    wr_ctl(1, ppgt_pkg::STOP_ONE_TIME, ppgt_pkg::SRC_CMD_CAP, 0);
    wait_for(0, 100);
    chk("one time", wn, 33);
    run_chk(0, 4);
    // capture: period 32, edges placed relative to the period pulse
    wr_ctl(1, ppgt_pkg::STOP_HOLD, ppgt_pkg::SRC_CMD_CAP, 0);
    apb(0, ppgt_pkg::OFS_FALL_HIGH, 0);
    wait_for(0, 100);
    pulse(2, 6);
    wait_for(0, 100);
    rd_cap(ra, fa);
    chk("edge gap", fa - ra, 4);
    wait_for(0, 100);
    rd_cap(a, b);
    chk("kept rise", a, ra);
    wait_for(0, 100);
    pulse(1, 3);
    pulse(2, 6);
    wait_for(0, 100);
    rd_cap(a, b);
    chk("last rise", a, ra + 3);
    chk("last fall", b, fa + 3);
    apb(0, ppgt_pkg::OFS_RISE_LOW, 0);
    wait_for(0, 100);
    pulse(2, 6);
    wait_for(0, 100);
    rd_cap(a, b);
    chk("guarded rise", a, ra + 3);
    wait_for(0, 100);
    rd_cap(a, b);
    chk("freed fall", b, fa);
    // trigger starts, rising polarity
    wr_ctl(0, ppgt_pkg::STOP_INIT, ppgt_pkg::SRC_TRG_ONLY, 1);
    lvl <= 1'b1;
    run_chk(0, 8);
    lvl <= 1'b0;
    wr_ctl(1, ppgt_pkg::STOP_INIT, ppgt_pkg::SRC_TRG_ONLY, 1);
    run_chk(0, 6);
    lvl <= 1'b1;
    wait_for(1, 20);
    run_chk(1, 2);
    lvl <= 1'b0;
    run_chk(0, 8);
    lvl <= 1'b1;
    wait_for(1, 20);
    wr_ctl(0, ppgt_pkg::STOP_ONE_TIME, ppgt_pkg::SRC_TRG_ONLY, 1);
    run_chk(1, 1);
    lvl <= 1'b0;
    run_chk(0, 8);
    lvl <= 1'b1;
    run_chk(0, 8);
    // command plus trigger, falling polarity, pin at stop level
    wr_ctl(1, ppgt_pkg::STOP_INIT, ppgt_pkg::SRC_CMD_TRG, 0);
    run_chk(0, 8);
    lvl <= 1'b0;
    wait_for(1, 20);
    run_chk(1, 2);
    lvl <= 1'b1;
    run_chk(0, 8);
    end_of_test;
  end
endmodule
